/* src/pbrc_cfg.svh */
/*
 constants for the push-button power and reset controller: timing counts
 and reset values. assumes a 200 MHz clock.
*/
`ifndef PBRC_CFG_SVH
`define PBRC_CFG_SVH
// ==========================================================================
// timing
`define PBRC_CLK_MHZ 200
`define PBRC_RAIL1_DELAY_MS 2
`define PBRC_RAIL2_DELAY_MS 4
`define PBRC_RAIL1_CYC (`PBRC_RAIL1_DELAY_MS * 1000 * `PBRC_CLK_MHZ)
`define PBRC_RAIL2_CYC (`PBRC_RAIL2_DELAY_MS * 1000 * `PBRC_CLK_MHZ)
`define PBRC_RST_TIMEOUT_CYC 1024
// ==========================================================================
// reset values
`define PBRC_UNMASK_RST 2'h0
`endif

/* src/pbrc_pkg.sv */
/*
 types shared by the push-button power and reset controller.
 assumes nothing beyond a SystemVerilog compiler.
*/
package pbrc_pkg;
   // ========================================================================
   // power sequencer states
   typedef enum logic [2:0] {
      PBRC_OFF,
      PBRC_RAMP,
      PBRC_BOOT,
      PBRC_ON
   } pbrc_state_e;
   // button function decoded from the input level and the hard-pull indication
   typedef enum logic [1:0] {
      PBRC_BTN_IDLE,
      PBRC_BTN_ENABLE,
      PBRC_BTN_MRESET
   } pbrc_btn_e;
endpackage

/* src/pbrc_tmr_if.sv */
/*
 interface between the controller and its reset time-out timer.
 assumes one clock domain.
*/
`timescale 1ns/1ps
interface pbrc_tmr_if;
   logic hold;
   logic expired;
   modport ctrl (output hold, input expired);
   modport tmr (input hold, output expired);
endinterface

/* src/pbrc_rst_timer.sv */
/*
 reset time-out timer: restarts while hold is high, flags expiry after a
 fixed count of clock cycles once hold drops.
 assumes synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "pbrc_cfg.svh"
module pbrc_rst_timer #(
   parameter int TIMEOUT_CYC = `PBRC_RST_TIMEOUT_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // timer port
   pbrc_tmr_if.tmr tif
);
   localparam int W = $clog2(TIMEOUT_CYC + 1);
   logic [W-1:0] cnt_q;
   // ========================================================================
   // counter: cleared by hold, stops at the time-out
   always_ff @(posedge clock) begin
      if (reset || tif.hold) begin
         cnt_q <= '0;
      end else if (cnt_q != W'(TIMEOUT_CYC)) begin
         cnt_q <= cnt_q + W'(1);
      end
   end
   assign tif.expired = (cnt_q == W'(TIMEOUT_CYC)) && !tif.hold;
endmodule

/* src/pbrc_ctrl.sv */
/*
 push-button power and reset controller: decodes the button input, runs
 the rail sequence, drives the cpu reset, button mirror and interrupt.
 assumes inputs synchronous to a 200 MHz clock; open-drain pins are
 returned as output and enable, the pad resolves them.
*/
`timescale 1ns/1ps
`include "pbrc_cfg.svh"
module pbrc_ctrl #(
   parameter int RST_TIMEOUT_CYC = `PBRC_RST_TIMEOUT_CYC,
   parameter int RAIL1_CYC = `PBRC_RAIL1_CYC,
   parameter int RAIL2_CYC = `PBRC_RAIL2_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // button input: low level and hard-pull indication from the pad detector
   input wire logic button_in_n,
   input wire logic button_hard_pull,
   // processor controls
   input wire logic power_enable_in,
   input wire logic power_hold_in,
   // rail three power-good
   input wire logic rail3_pgood,
   // interrupt sources and software unmask bits
   input wire logic sysvolt_status,
   input wire logic fault_status,
   input wire logic sysvolt_irq_unmask_wr,
   input wire logic sysvolt_irq_unmask_val,
   input wire logic fault_irq_unmask_wr,
   input wire logic fault_irq_unmask_val,
   // rail enables
   output logic [7:1] rail_enable,
   // open-drain pins: output level and enable
   output logic cpu_reset_out_n_o,
   output logic cpu_reset_out_n_oe,
   output logic button_state_out_n_o,
   output logic button_state_out_n_oe,
   output logic interrupt_out_n_o,
   output logic interrupt_out_n_oe,
   // status
   output logic sysvolt_irq_unmask,
   output logic fault_irq_unmask,
   output logic powered
);
   localparam int SW = $clog2(RAIL2_CYC + 1);
   pbrc_pkg::pbrc_state_e st_q;
   pbrc_pkg::pbrc_btn_e btn;
   logic [SW-1:0] seq_q;
   logic rst_q, irq_q;
   logic r1_q, r2_q, r3_q, r47_q;
   logic pressed;
   pbrc_tmr_if tif ();

   // ========================================================================
   // button decode
   always_comb begin
      if (button_in_n) begin
         btn = pbrc_pkg::PBRC_BTN_IDLE;
      end else if (button_hard_pull) begin
         btn = pbrc_pkg::PBRC_BTN_MRESET;
      end else begin
         btn = pbrc_pkg::PBRC_BTN_ENABLE;
      end
   end
   assign pressed = !button_in_n;

   // ========================================================================
   // power sequencer
   always_ff @(posedge clock) begin
      if (reset) begin
         st_q <= pbrc_pkg::PBRC_OFF;
      end else begin
         case (st_q)
            pbrc_pkg::PBRC_OFF: begin
               if (btn == pbrc_pkg::PBRC_BTN_ENABLE) begin
                  st_q <= pbrc_pkg::PBRC_RAMP;
               end
            end
            pbrc_pkg::PBRC_RAMP, pbrc_pkg::PBRC_BOOT: begin
               if (power_enable_in || power_hold_in) begin
                  st_q <= pbrc_pkg::PBRC_ON;
               end else if (!pressed) begin
                  st_q <= pbrc_pkg::PBRC_OFF;
               end else if (rail3_pgood) begin
                  st_q <= pbrc_pkg::PBRC_BOOT;
               end
            end
            pbrc_pkg::PBRC_ON: begin
               if (!power_enable_in && !power_hold_in && !pressed) begin
                  st_q <= pbrc_pkg::PBRC_OFF;
               end
            end
            default: st_q <= pbrc_pkg::PBRC_OFF;
         endcase
      end
   end
   assign powered = (st_q != pbrc_pkg::PBRC_OFF);

   // delay count from rail three power-good
   always_ff @(posedge clock) begin
      if (reset || !powered || !rail3_pgood) begin
         seq_q <= '0;
      end else if (seq_q != SW'(RAIL2_CYC)) begin
         seq_q <= seq_q + SW'(1);
      end
   end

   // rail enables: three first, one and two after delays
   always_ff @(posedge clock) begin
      if (reset) begin
         r1_q <= 1'b0;
         r2_q <= 1'b0;
         r3_q <= 1'b0;
         r47_q <= 1'b0;
      end else begin
         r3_q <= powered;
         r1_q <= powered && (r1_q || seq_q >= SW'(RAIL1_CYC));
         r2_q <= powered && (r2_q || seq_q >= SW'(RAIL2_CYC));
         r47_q <= (st_q == pbrc_pkg::PBRC_ON) && power_enable_in;
      end
   end
   assign rail_enable = {{4{r47_q}}, r3_q, r2_q, r1_q};

   // ========================================================================
   // reset time-out timer
   pbrc_rst_timer #(
      .TIMEOUT_CYC(RST_TIMEOUT_CYC)
   ) u_tmr (
      .clock(clock),
      .reset(reset),
      .tif(tif.tmr)
   );
   // timer holds while manual reset pressed or rail three not good
   assign tif.hold = (btn == pbrc_pkg::PBRC_BTN_MRESET) || !rail3_pgood || !powered;

   // cpu reset released once the timer expires; a manual press holds the timer,
   // so release plus a full time-out comes out of the same path
   always_ff @(posedge clock) begin
      if (reset) begin
         rst_q <= 1'b1;
      end else begin
         rst_q <= !tif.expired;
      end
   end
   // manual reset pulls low in the same cycle
   assign cpu_reset_out_n_o = 1'b0;
   assign cpu_reset_out_n_oe = rst_q || (btn == pbrc_pkg::PBRC_BTN_MRESET);

   // button mirror
   assign button_state_out_n_o = 1'b0;
   assign button_state_out_n_oe = pressed;

   // ========================================================================
   // interrupt masks and output
   always_ff @(posedge clock) begin
      if (reset) begin
         {sysvolt_irq_unmask, fault_irq_unmask} <= `PBRC_UNMASK_RST;
      end else begin
         if (sysvolt_irq_unmask_wr) begin
            sysvolt_irq_unmask <= sysvolt_irq_unmask_val;
         end
         if (fault_irq_unmask_wr) begin
            fault_irq_unmask <= fault_irq_unmask_val;
         end
      end
   end
   always_ff @(posedge clock) begin
      if (reset) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= (sysvolt_status && sysvolt_irq_unmask) ||
                  (fault_status && fault_irq_unmask);
      end
   end
   assign interrupt_out_n_o = 1'b0;
   assign interrupt_out_n_oe = irq_q;

   // ========================================================================
   // checks
   // release while powering up, with the processor not yet in control
   sequence s_false_release;
      powered && (st_q != pbrc_pkg::PBRC_ON) && button_in_n &&
      !power_enable_in && !power_hold_in;
   endsequence
   // sequencer drops power, then every rail is off
   sequence s_shut_down;
      !powered ##1 (rail_enable == 7'h00);
   endsequence
   // manual reset press followed by its release
   sequence s_mr_release;
      (btn == pbrc_pkg::PBRC_BTN_MRESET) ##1 button_in_n;
   endsequence
   a_mreset_now: assert property (@(posedge clock) disable iff (reset)
      !button_in_n && button_hard_pull |-> cpu_reset_out_n_oe)
      else $error("manual reset did not pull cpu reset low");
   a_mreset_hold: assert property (@(posedge clock) disable iff (reset)
      s_mr_release |-> cpu_reset_out_n_oe)
      else $error("cpu reset released together with the button");
   a_mirror_level: assert property (@(posedge clock) disable iff (reset)
      button_state_out_n_oe == !button_in_n)
      else $error("button mirror wrong");
   a_rst_hold_pg: assert property (@(posedge clock) disable iff (reset)
      !rail3_pgood |=> cpu_reset_out_n_oe)
      else $error("cpu reset released without power-good");
   a_irq_unmasked: assert property (@(posedge clock) disable iff (reset)
      (sysvolt_status && sysvolt_irq_unmask) || (fault_status && fault_irq_unmask)
      |=> !interrupt_out_n_o && interrupt_out_n_oe)
      else $error("unmasked interrupt not driven");
   a_mask_reset: assert property (@(posedge clock)
      $fell(reset) |-> !sysvolt_irq_unmask && !fault_irq_unmask)
      else $error("masks not cleared by reset");
   a_start_press: assert property (@(posedge clock) disable iff (reset)
      st_q == pbrc_pkg::PBRC_OFF && btn == pbrc_pkg::PBRC_BTN_ENABLE |=> powered)
      else $error("press did not start power-on");
   a_false_enable: assert property (@(posedge clock) disable iff (reset)
      s_false_release |=> s_shut_down)
      else $error("rails kept after false enable");
   a_rail3_first: assert property (@(posedge clock) disable iff (reset)
      rail_enable[1] || rail_enable[2] |-> rail_enable[3])
      else $error("rail order wrong");
   a_hold_r47: assert property (@(posedge clock) disable iff (reset)
      !power_enable_in |=> rail_enable[7:4] == 4'h0)
      else $error("rails four to seven on without enable");
endmodule

/* sim/pbrc_partner.sv */
/* model of the user button and the processor.
   assumes bench-driven press, hard, take and sleep levels on the bench clock. */
`timescale 1ns/1ps
module pbrc_partner #(
   parameter int DLY = 30
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // bench controls
   input wire logic press,
   input wire logic hard,
   input wire logic take,
   input wire logic sleep,
   // device side
   input wire logic rail3_on,
   input wire logic cpu_reset_pin,
   output logic button_in_n,
   output logic button_hard_pull,
   output logic power_enable_in,
   output logic power_hold_in,
   output logic rail3_pgood
);
   logic [2:0] pg_q;
   int wait_q;
   // ========================================================================
   // button contacts follow the bench press
   assign button_in_n = !press;
   assign button_hard_pull = press & hard;
   // rail three settles three cycles after its enable
   always_ff @(posedge clock) begin
      pg_q <= reset ? 3'h0 : {pg_q[1:0], rail3_on};
   end
   assign rail3_pgood = pg_q[2];
   // processor takes power DLY+1 cycles after leaving reset, keeps it while take
   always_ff @(posedge clock) begin
      if (reset || !take) wait_q <= 0;
      else if (cpu_reset_pin && wait_q <= DLY) wait_q <= wait_q + 1;
   end
   assign power_hold_in = wait_q > DLY;
   // enable follows hold unless the bench asks for sleep
   assign power_enable_in = power_hold_in && !sleep;
endmodule

/* sim/testbench.sv */
/* self-checking bench for the push-button power and reset controller.
   assumes the partner model and shortened timing parameters. */
`timescale 1ns/1ps
module testbench;
   typedef struct {int id; logic [7:0] v;} pbrc_note_s;
   localparam int TO = 16;
   localparam int R1 = 20;
   localparam int R2 = 40;
   logic clock = 0, reset = 1, press = 0, hard = 0, take = 0, sleep = 0, sm = 0, fm = 0;
   logic sv_st = 0, ft_st = 0, sv_wr = 0, sv_v = 0, ft_wr = 0, ft_v = 0;
   logic bin_n, hp, pen, phl, pg, pwr, sv_m, ft_m, r_o, r_oe, b_o, b_oe, i_o, i_oe;
   logic [7:1] rails;
   logic [7:0] rnd = 8'h32;
   logic mq[$];
   int bad_count = 0, samples_checked = 0, cyc = 0;
   string nm[8] = '{"rails", "reset_pin", "button_pin", "irq_pin", "masks", "powered",
      "timing", "pgood"};
   pbrc_note_s q[$];
   wire rst_pin = r_oe ? r_o : 1'b1;
   always #2.5 clock = ~clock;
   // ========================================================================
   // design and partner
   pbrc_ctrl #(.RST_TIMEOUT_CYC(TO), .RAIL1_CYC(R1), .RAIL2_CYC(R2)) i_pbrc_ctrl (
      .clock(clock), .reset(reset), .button_in_n(bin_n), .button_hard_pull(hp),
      .power_enable_in(pen), .power_hold_in(phl), .rail3_pgood(pg),
      .sysvolt_status(sv_st), .fault_status(ft_st), .sysvolt_irq_unmask_wr(sv_wr),
      .sysvolt_irq_unmask_val(sv_v), .fault_irq_unmask_wr(ft_wr),
      .fault_irq_unmask_val(ft_v), .rail_enable(rails), .cpu_reset_out_n_o(r_o),
      .cpu_reset_out_n_oe(r_oe), .button_state_out_n_o(b_o),
      .button_state_out_n_oe(b_oe), .interrupt_out_n_o(i_o),
      .interrupt_out_n_oe(i_oe), .sysvolt_irq_unmask(sv_m), .fault_irq_unmask(ft_m),
      .powered(pwr));
   pbrc_partner #(.DLY(30)) i_pbrc_partner (
      .clock(clock), .reset(reset), .press(press), .hard(hard), .take(take), .sleep(sleep),
      .rail3_on(rails[3]), .cpu_reset_pin(rst_pin), .button_in_n(bin_n),
      .button_hard_pull(hp), .power_enable_in(pen), .power_hold_in(phl),
      .rail3_pgood(pg));
   // ========================================================================
   // helpers
   function automatic logic [7:0] nx(logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [7:0] obs(int id);
      case (id)
         0: return {rails, 1'b0};
         1: return {7'h00, rst_pin};
         2: return {7'h00, b_oe ? b_o : 1'b1};
         3: return {7'h00, i_oe ? i_o : 1'b1};
         4: return {6'h00, sv_m, ft_m};
         5: return {7'h00, pwr};
         7: return {7'h00, pg};
         default: return 8'h00;
      endcase
   endfunction
   task automatic tick(int n = 1);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic note(int id, logic [7:0] v);
      q.push_back('{id, v});
   endtask
   // wait for a level, then record whether the wait fell within lo..hi cycles
   task automatic wait_in(int id, logic [7:0] v, int lo, int hi);
      int n;
      n = 0;
      while (obs(id) !== v && n < 2000) begin
         tick();
         n++;
      end
      mq.push_back(n >= lo && n <= hi);
      note(6, 8'h01);
   endtask
   task automatic complete_run();
      if (bad_count == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // compare a pin or status level against its note
   task automatic check_level(int id, logic [7:0] v);
      samples_checked++;
      if (obs(id) !== v) begin
         bad_count++;
         $display("unexpected %s exp %h got %h", nm[id], v, obs(id));
      end
   endtask
   // compare the oldest measured wait against its window verdict
   task automatic check_time(logic [7:0] v);
      logic [7:0] seen;
      seen = 8'h00;
      seen[0] = mq.pop_front();
      samples_checked++;
      if (seen !== v) begin
         bad_count++;
         $display("unexpected %s exp %h got %h", nm[6], v, seen);
      end
   endtask
   // compare pending notes at the falling edge, where outputs have settled
   always @(negedge clock) begin
      while (q.size() > 0) begin
         pbrc_note_s n;
         n = q.pop_front();
         if (n.id == 6) begin
            check_time(n.v);
         end else begin
            check_level(n.id, n.v);
         end
      end
   end
   // hang guard
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         complete_run();
      end
   end
   // ========================================================================
   // main sequence
   initial begin
      tick(2);
      reset = 0;
      note(0, 8'h00);
      note(1, 8'h00);
      note(2, 8'h01);
      note(3, 8'h01);
      note(4, 8'h00);
      tick();
      // short press with no processor take ends in shutdown
      press = 1;
      tick(2);
      note(2, 8'h00);
      note(5, 8'h01);
      note(0, 8'h08);
      note(1, 8'h00);
      tick(6);
      press = 0;
      tick(2);
      note(0, 8'h00);
      note(5, 8'h00);
      tick(5);
      // full power-on with the processor taking over
      take = 1;
      press = 1;
      wait_in(7, 8'h01, 3, 6);
      wait_in(1, 8'h01, TO - 1, TO + 3);
      wait_in(0, 8'h0A, R1 - TO - 4, R1 - TO + 2);
      wait_in(0, 8'h0E, R2 - R1 - 2, R2 - R1 + 2);
      wait_in(0, 8'hFE, 2, 14);
      press = 0;
      tick(3);
      note(0, 8'hFE);
      // manual reset held for rnd[3:0]+2 cycles, four with the starting seed 8'h32
      hard = 1;
      press = 1;
      note(1, 8'h00);
      tick(rnd[3:0] + 2);
      press = 0;
      hard = 0;
      note(1, 8'h00);
      wait_in(1, 8'h01, TO - 1, TO + 3);
      note(0, 8'hFE);
      // processor drops enable for sleep, hold keeps rails one to three
      sleep = 1;
      tick(3);
      note(0, 8'h0E);
      sleep = 0;
      tick(3);
      note(0, 8'hFE);
      // random unmask writes against random interrupt conditions
      repeat (8) begin
         rnd = nx(rnd);
         {sv_st, ft_st, sv_v, ft_v, sv_wr, ft_wr} = rnd[5:0];
         if (sv_wr) sm = sv_v;
         if (ft_wr) fm = ft_v;
         tick();
         {sv_wr, ft_wr} = 2'h0;
         tick();
         note(4, {6'h00, sm, fm});
         note(3, {7'h00, !(sv_st & sm | ft_st & fm)});
      end
      // processor lets go of power
      take = 0;
      tick(3);
      note(0, 8'h00);
      tick(2);
      complete_run();
   end
endmodule
